// ==== include/sep_pkg.sv ====
// Constants, types and decode helpers for the two-wire serial memory slave.
// Assumes a 50 MHz system clock; shared by the slave and its testbench.
package sep_pkg;
   localparam int SEP_ARRAY_AW = 13;
   localparam int SEP_ARRAY_DEPTH = 8192;
   localparam int SEP_PAGE_AW = 5;
   localparam int SEP_PAGE_BYTES = 32;
   localparam logic [15:0] SEP_WPR_ADDR = 16'hFFFF;
   // Protection register field positions
   localparam int SEP_WPR_ARM_BIT = 7;
   localparam int SEP_WPR_BLH_BIT = 4;
   localparam int SEP_WPR_BLL_BIT = 3;
   localparam int SEP_WPR_RWEL_BIT = 2;
   localparam int SEP_WPR_WEL_BIT = 1;
   localparam logic [7:0] SEP_WPR_UNUSED_MASK = 8'h61;
   localparam logic [7:0] SEP_WPR_SET_WEL = 8'h02;
   localparam logic [7:0] SEP_WPR_SET_RWEL = 8'h06;
   localparam logic [7:0] SEP_WPR_CLEAR = 8'h00;
   localparam logic SEP_WPR_BIT_RESET = 1'b0;
   // Arbitrary device-type code, not tied to any real part
   localparam logic [3:0] SEP_DEV_TYPE = 4'h5;
   // Self-timed write cycle
   localparam int SEP_CLK_MHZ = 50;
   localparam int SEP_WRITE_CYCLE_US = 5000;
   localparam int SEP_WRITE_CYCLES = SEP_WRITE_CYCLE_US * SEP_CLK_MHZ;
   localparam int SEP_TMR_W = 20;
   localparam logic [5:0] SEP_PIN_RESET = 6'h03;

   typedef enum logic [2:0] {
      SEP_IDLE, SEP_DEVADDR, SEP_ADDR_HI, SEP_ADDR_LO, SEP_WDATA, SEP_RDATA
   } sep_state_e;

   // Upper quarter for 01, upper half for 10, everything for 11
   function automatic logic sep_locked(input logic [12:0] addr, input logic [1:0] bl);
      case (bl)
         2'b01: sep_locked = (addr[12:11] == 2'b11);
         2'b10: sep_locked = addr[12];
         2'b11: sep_locked = 1'b1;
         default: sep_locked = 1'b0;
      endcase
   endfunction
endpackage

// ==== rtl/sep_mem.sv ====
// Single-port byte memory with registered read data.
// Assumes one access per cycle; read data follow the address by one cycle.
`timescale 1ns/1ns
`default_nettype none
module sep_mem #(
   parameter int AW = 13,
   parameter int DEPTH = 8192
) (
   // Clock
   input wire logic clk_in,
   input wire logic ce_in,
   // Access
   input wire logic we_in,
   input wire logic [AW-1:0] addr_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rdata_out
);
   logic [7:0] mem_r [DEPTH];

   always_ff @(posedge clk_in) begin
      if (ce_in) begin
         if (we_in) begin
            mem_r[addr_in] <= wdata_in;
         end
         rdata_out <= mem_r[addr_in];
      end
   end
endmodule
`default_nettype wire

// ==== rtl/sep_slave.sv ====
// Two-wire serial memory slave: bus engine, page buffer, protection register.
// Assumes bus lines and straps arrive asynchronously and are resampled here.
`timescale 1ns/1ns
`default_nettype none
// Operation
// R1 - Data moves only while clock low; high-clock data edges mean start or stop.
// R2 - Watch lines always for start; ignore everything until a start is seen.
// R3 - A stop ends each transfer and returns the slave to standby.
// R4 - Transmitter releases data after eight bits; receiver pulls low on ninth clock.
// R5 - Acknowledge a matching slave address and every later byte of a write; code acks only the first data byte to the register at FFFFh.
// R6 - On reads send eight bits, then continue only if master acknowledged.
// R7 - Master withholding read acknowledge must then issue a stop.
// R8 - Address byte: four-bit type code, three select bits, direction bit.
// R9 - Direction bit one means read, zero means write.
// R10 - Mismatch of type or select: no acknowledge, back to standby.
// R11 - Master sends two word-address bytes, high byte first.
// R12 - Array is 256 pages of 32 bytes.
// R13 - Byte index is low address bits 4..0; page is the rest.
// R14 - Byte write: ack address, ack data, start write cycle at stop.
// R15 - During write cycle inputs are ignored and data line released.
// R16 - Page write accepts up to thirty-one more acknowledged bytes.
// R17 - Only byte index increments, wrapping inside the page.
// R18 - Bytes beyond 32 overwrite earlier bytes at the wrapped position.
// R19 - No nonvolatile write while the software write latch is clear.
// R20 - Protection register sits at address FFFFh on the same path.
// R21 - Two lock bits protect none, a quarter, half or all.
// R22 - Pin high and arm bit set freeze lock bits and arm bit.
// R23 - While busy, the slave address is not acknowledged.
// R24 - Writes to locked regions are acknowledged but start no write cycle.
// R25 - Address counter holds last address plus one, wrapping after the top.
// R26 - Hardware protection is active only when pin and arm bit are high.
// R27 - Bytes move most significant bit first, sampled on rising clock.
// R28 - Lock patterns map to upper quarter, upper half and whole array.
module sep_slave
   import sep_pkg::*;
#(
   parameter int WRITE_CYCLES = SEP_WRITE_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic ce_in,
   // Two-wire bus
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // Straps
   input wire logic select_pin_0_in,
   input wire logic select_pin_1_in,
   input wire logic select_pin_2_in,
   input wire logic write_protect_pin_in,
   // Status
   output logic write_busy_out
);
   logic [5:0] s1_r, s2_r, s3_r, filt_r;
   logic prev_scl_r, prev_sda_r, scl_f, sda_f, scl_rise, scl_fall, start_det, stop_det, wp_f;
   logic [2:0] sel_f;
   sep_state_e state_r;
   logic [3:0] cnt_r;
   logic [7:0] shift_r, tx_r, addr_hi_r, reg_data_r, rd_byte, wpr, pb_rdata, arr_rdata;
   logic ack_r, tx_mode_r, macked_r, got_data_r, wel_r, rwel_r, arm_r, busy_r;
   logic [15:0] addr_r;
   logic [SEP_PAGE_BYTES-1:0] mask_r;
   logic [1:0] bl_r;
   logic [SEP_TMR_W-1:0] tmr_r;
   logic byte_done, ack_end, dev_match, ack_now, wdata_accept, is_wpr;
   logic hw_prot, wpr_nv_ok, start_wc, copy_we;
   logic [4:0] copy_idx;
   logic [12:0] arr_addr;

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);

   // Three-stage resample; a level counts once stages two and three agree
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         s1_r <= SEP_PIN_RESET;
         s2_r <= SEP_PIN_RESET;
         s3_r <= SEP_PIN_RESET;
         filt_r <= SEP_PIN_RESET;
         prev_scl_r <= 1'b1;
         prev_sda_r <= 1'b1;
      end else if (ce_in) begin
         s1_r <= {write_protect_pin_in, select_pin_2_in, select_pin_1_in,
                  select_pin_0_in, sda_in, scl_in};
         s2_r <= s1_r;
         s3_r <= s2_r;
         filt_r <= (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
         prev_scl_r <= filt_r[0];
         prev_sda_r <= filt_r[1];
      end
   end

   always_comb begin
      scl_f = filt_r[0];
      sda_f = filt_r[1];
      sel_f = filt_r[4:2];
      wp_f = filt_r[5];
      scl_rise = ce_in & scl_f & ~prev_scl_r;
      scl_fall = ce_in & ~scl_f & prev_scl_r;
      // Data edges while clock stays high are framing, never data
      start_det = ce_in & scl_f & prev_scl_r & prev_sda_r & ~sda_f & ~busy_r; // R1 R2 R15 R23
      stop_det = ce_in & scl_f & prev_scl_r & ~prev_sda_r & sda_f & ~busy_r; // R1 R3
      byte_done = scl_fall & (cnt_r == 4'd8) & (state_r != SEP_IDLE);
      ack_end = scl_fall & (cnt_r == 4'd9) & (state_r != SEP_IDLE);
      dev_match = (shift_r[7:4] == SEP_DEV_TYPE) && (shift_r[3:1] == sel_f); // R8
      is_wpr = (addr_r == SEP_WPR_ADDR); // R20
      case (state_r)
         SEP_DEVADDR: ack_now = dev_match; // R5 R10
         SEP_ADDR_HI: ack_now = 1'b1;
         SEP_ADDR_LO: ack_now = 1'b1;
         // The register takes a single data byte
         SEP_WDATA: ack_now = ~(is_wpr & got_data_r); // R5 R16
         default: ack_now = 1'b0;
      endcase
      wdata_accept = byte_done & (state_r == SEP_WDATA) & ack_now;
      hw_prot = wp_f & arm_r; // R26
      wpr_nv_ok = ((reg_data_r & SEP_WPR_UNUSED_MASK) == 8'h00)
         & reg_data_r[SEP_WPR_WEL_BIT] & reg_data_r[SEP_WPR_RWEL_BIT]
         & wel_r & rwel_r & ~hw_prot & (reg_data_r != SEP_WPR_SET_RWEL); // R22
      // A locked or unlatched write is acknowledged yet never programmed
      start_wc = stop_det & (state_r == SEP_WDATA) & got_data_r & wel_r
         & (is_wpr ? wpr_nv_ok : ~sep_locked(addr_r[12:0], bl_r)); // R14 R19 R24 R28
      wpr = 8'h00;
      wpr[SEP_WPR_ARM_BIT] = arm_r;
      wpr[SEP_WPR_BLH_BIT] = bl_r[1];
      wpr[SEP_WPR_BLL_BIT] = bl_r[0];
      wpr[SEP_WPR_RWEL_BIT] = rwel_r;
      wpr[SEP_WPR_WEL_BIT] = wel_r;
      rd_byte = is_wpr ? wpr : arr_rdata; // R20
      sda_out = 1'b0;
      // Open drain: only ever pull low
      sda_oe_out = ~busy_r & (ack_r | (tx_mode_r & ~tx_r[7])); // R4 R15
      write_busy_out = busy_r;
   end

   // Bus engine: framing, bit counting, acknowledge and transmit
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         state_r <= SEP_IDLE;
         cnt_r <= 4'd0;
         shift_r <= 8'h00;
         tx_r <= 8'hFF;
         ack_r <= 1'b0;
         tx_mode_r <= 1'b0;
         macked_r <= 1'b0;
         addr_hi_r <= 8'h00;
         got_data_r <= 1'b0;
         reg_data_r <= 8'h00;
      end else if (start_det) begin
         state_r <= SEP_DEVADDR; // R2
         cnt_r <= 4'd0;
         ack_r <= 1'b0;
         tx_mode_r <= 1'b0;
      end else if (stop_det) begin
         state_r <= SEP_IDLE; // R3
         ack_r <= 1'b0;
         tx_mode_r <= 1'b0;
      end else if (state_r != SEP_IDLE) begin
         if (scl_rise) begin
            if (cnt_r < 4'd8) begin
               shift_r <= {shift_r[6:0], sda_f}; // R27
               cnt_r <= cnt_r + 4'd1;
            end else if (cnt_r == 4'd8) begin
               macked_r <= ~sda_f; // R6
               cnt_r <= 4'd9;
            end
         end else if (byte_done) begin
            tx_mode_r <= 1'b0; // R4
            ack_r <= ack_now; // R4 R5 R10
            case (state_r)
               SEP_DEVADDR: begin
                  if (!dev_match) begin
                     state_r <= SEP_IDLE; // R10
                  end else if (shift_r[0]) begin
                     state_r <= SEP_RDATA; // R9
                  end else begin
                     state_r <= SEP_ADDR_HI; // R9
                  end
               end
               SEP_ADDR_HI: begin
                  addr_hi_r <= shift_r; // R11
                  state_r <= SEP_ADDR_LO;
               end
               SEP_ADDR_LO: begin
                  state_r <= SEP_WDATA;
                  got_data_r <= 1'b0;
               end
               SEP_WDATA: begin
                  if (ack_now) begin
                     got_data_r <= 1'b1;
                     reg_data_r <= shift_r;
                  end
               end
               default: ;
            endcase
         end else if (ack_end) begin
            ack_r <= 1'b0;
            cnt_r <= 4'd0;
            if (state_r == SEP_RDATA) begin
               if (macked_r) begin
                  tx_r <= rd_byte; // R6
                  tx_mode_r <= 1'b1;
               end else begin
                  state_r <= SEP_IDLE; // R6
               end
            end
         end else if (scl_fall && tx_mode_r && cnt_r != 4'd0 && cnt_r < 4'd8) begin
            tx_r <= {tx_r[6:0], 1'b1}; // R27
         end
      end
   end

   // Address counter
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         addr_r <= 16'h0000;
      end else if (byte_done && state_r == SEP_ADDR_LO) begin
         addr_r <= {addr_hi_r, shift_r}; // R11 R13
      end else if (wdata_accept && !is_wpr) begin
         // Page bits are held; only the byte index moves and wraps
         addr_r[4:0] <= addr_r[4:0] + 5'd1; // R13 R17
      end else if (ack_end && state_r == SEP_RDATA && macked_r) begin
         if (is_wpr) begin
            addr_r <= 16'h0000;
         end else begin
            addr_r <= {3'b000, addr_r[12:0] + 13'd1}; // R25
         end
      end
   end

   // Page load mask; a reloaded position simply overwrites its buffer byte
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         mask_r <= '0;
      end else if (byte_done && state_r == SEP_ADDR_LO) begin
         mask_r <= '0;
      end else if (wdata_accept && !is_wpr) begin
         mask_r[addr_r[4:0]] <= 1'b1; // R16 R18
      end
   end

   // Protection register; volatile latches act at stop without a write cycle
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         wel_r <= SEP_WPR_BIT_RESET;
         rwel_r <= SEP_WPR_BIT_RESET;
         arm_r <= SEP_WPR_BIT_RESET;
         bl_r <= {SEP_WPR_BIT_RESET, SEP_WPR_BIT_RESET};
      end else if (stop_det && state_r == SEP_WDATA && got_data_r && is_wpr) begin
         if (reg_data_r == SEP_WPR_SET_WEL) begin
            wel_r <= 1'b1;
         end else if (reg_data_r == SEP_WPR_SET_RWEL) begin
            rwel_r <= wel_r;
         end else if (reg_data_r == SEP_WPR_CLEAR) begin
            wel_r <= 1'b0;
            rwel_r <= 1'b0;
         end else if (wpr_nv_ok) begin
            arm_r <= reg_data_r[SEP_WPR_ARM_BIT]; // R22
            bl_r <= {reg_data_r[SEP_WPR_BLH_BIT], reg_data_r[SEP_WPR_BLL_BIT]}; // R21
            rwel_r <= 1'b0;
         end
      end
   end

   // Self-timed write: copy loaded bytes into the page, then wait out the cycle
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         busy_r <= 1'b0;
         tmr_r <= '0;
      end else if (ce_in) begin
         if (start_wc) begin
            busy_r <= 1'b1; // R14 R15
            tmr_r <= '0;
         end else if (busy_r) begin
            tmr_r <= tmr_r + 1'b1;
            if (tmr_r == SEP_TMR_W'(WRITE_CYCLES - 1)) begin
               busy_r <= 1'b0;
            end
         end
      end
   end

   always_comb begin
      copy_idx = 5'(tmr_r - 1'b1);
      copy_we = busy_r && (tmr_r >= 1) && (tmr_r <= SEP_PAGE_BYTES) && mask_r[copy_idx];
      arr_addr = busy_r ? {addr_r[12:5], copy_idx} : addr_r[12:0]; // R12 R13
   end

   sep_mem #(.AW(SEP_PAGE_AW), .DEPTH(SEP_PAGE_BYTES)) u_page (
      .clk_in(ref_clk_in),
      .ce_in(ce_in),
      .we_in(wdata_accept & ~is_wpr),
      .addr_in(busy_r ? tmr_r[4:0] : addr_r[4:0]),
      .wdata_in(shift_r),
      .rdata_out(pb_rdata)
   );

   sep_mem #(.AW(SEP_ARRAY_AW), .DEPTH(SEP_ARRAY_DEPTH)) u_array (
      .clk_in(ref_clk_in),
      .ce_in(ce_in),
      .we_in(copy_we),
      .addr_in(arr_addr),
      .wdata_in(pb_rdata),
      .rdata_out(arr_rdata)
   );

   a_busy_released: assert property (busy_r |-> !sda_oe_out && !ack_r && !tx_mode_r) // R15
      else $error("data line driven during write cycle");
   a_busy_no_start: assert property (busy_r && state_r == SEP_IDLE |=> state_r == SEP_IDLE) // R23
      else $error("bus engine woke while busy");
   a_mismatch_nack: assert property ( // R10
      byte_done && state_r == SEP_DEVADDR && !dev_match |=> !ack_r && state_r == SEP_IDLE)
      else $error("mismatched address acknowledged");
   a_match_ack: assert property ( // R5
      byte_done && state_r == SEP_DEVADDR && dev_match |=> ack_r && sda_oe_out)
      else $error("matching address not acknowledged");
   a_ack_release: assert property (ack_end |=> !ack_r) // R4
      else $error("acknowledge held past ninth clock");
   a_start_arms: assert property ( // R2
      start_det |=> state_r == SEP_DEVADDR && cnt_r == 4'd0 && !sda_oe_out)
      else $error("start did not rearm address phase");
   a_wel_gate: assert property (stop_det && !wel_r |=> !busy_r) // R19
      else $error("write cycle started with latch clear");
   a_lock_gate: assert property ( // R24
      stop_det && !is_wpr && sep_locked(addr_r[12:0], bl_r) |=> !busy_r)
      else $error("write cycle started on locked region");
   a_page_wrap: assert property ( // R17
      wdata_accept && !is_wpr && addr_r[4:0] == 5'd31
      |=> addr_r[4:0] == 5'd0 && addr_r[12:5] == $past(addr_r[12:5]))
      else $error("byte index did not wrap inside page");
   a_hw_freeze: assert property (hw_prot && ce_in |=> $stable({arm_r, bl_r})) // R22
      else $error("protected bits changed under hardware protection");
   a_cycle_length: assert property ( // R15
      busy_r && tmr_r < SEP_TMR_W'(WRITE_CYCLES - 1) |=> busy_r)
      else $error("write cycle ended early");
endmodule
`default_nettype wire

// ==== tb/sep_master_model.sv ====
// Two-wire bus master model: drives the serial clock and pulls the data line low.
// Assumes the bench resolves the data line with a pull-up and feeds it back in.
`timescale 1ns/1ns
`default_nettype none
module sep_master_model (
   // Clock
   input wire logic clk_in,
   // Bus
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_low_out
);
   // Serial clock stands high between frames
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   // Bit period is 15 system cycles, not 8: the slave resamples and needs six per phase
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // Data moves late in the low phase, after the slave lets go of its acknowledge
   task automatic bit_io(input logic b, output logic got);
      tick(6);
      sda_low_out = ~b;
      tick(3);
      scl_out = 1'b1;
      tick(6);
      got = sda_in;
      scl_out = 1'b0;
   endtask
   // Falling data while the clock is high, also as a repeated start
   task automatic start();
      if (!scl_out) begin
         tick(6);
         sda_low_out = 1'b0;
         tick(3);
         scl_out = 1'b1;
      end
      tick(6);
      sda_low_out = 1'b1;
      tick(6);
      scl_out = 1'b0;
   endtask
   // Rising data while the clock is high
   task automatic stop();
      tick(6);
      sda_low_out = 1'b1;
      tick(3);
      scl_out = 1'b1;
      tick(6);
      sda_low_out = 1'b0;
      tick(6);
   endtask
   // Most significant bit first, then the line is released for the ninth clock
   task automatic send(input logic [7:0] b, output logic ack);
      logic g;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], g);
      bit_io(1'b1, g);
      ack = ~g;
   endtask
   // Acknowledge asks for more; withheld, the caller must follow with a stop
   task automatic recv(input logic ack, output logic [7:0] b);
      logic g;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, b[i]);
      bit_io(~ack, g);
   endtask
endmodule
`default_nettype wire

// ==== tb/test_serial_eeprom_slave_write_path.sv ====
// Self-checking bench for the serial memory slave, driven through a bus master model.
// Assumes the slave's default device-type code and a shortened write cycle.
`timescale 1ns/1ns
`default_nettype none
module test_serial_eeprom_slave_write_path;
   import sep_pkg::*;
   localparam logic [2:0] SEL = 3'b101;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic [2:0] sel = SEL;
   logic wp = 1'b0;
   logic scl;
   logic m_low;
   logic sda_o;
   logic sda_oe;
   logic busy;
   wire sda_line;
   int errors = 0;
   int total_checks = 0;
   logic k;
   logic [7:0] pg[$];
   logic [7:0] ex[$];
   // Open-drain line with a pull-up
   assign sda_line = ~(m_low | (sda_oe & ~sda_o));
   always #10 ref_clk = ~ref_clk;
   sep_slave #(.WRITE_CYCLES(300)) u_dut (
      .ref_clk_in(ref_clk),
      .srst_in(srst),
      .ce_in(1'b1),
      .scl_in(scl),
      .sda_in(sda_line),
      .sda_out(sda_o),
      .sda_oe_out(sda_oe),
      .select_pin_0_in(sel[0]),
      .select_pin_1_in(sel[1]),
      .select_pin_2_in(sel[2]),
      .write_protect_pin_in(wp),
      .write_busy_out(busy)
   );
   sep_master_model u_m (
      .clk_in(ref_clk),
      .sda_in(sda_line),
      .scl_out(scl),
      .sda_low_out(m_low)
   );
   task automatic report_and_stop();
      $display("errors %0d total_checks %0d", errors, total_checks);
      if (errors == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] dev(input logic rw);
      return {SEP_DEV_TYPE, SEL, rw};
   endfunction
   // A poll during the cycle must go unanswered, then the cycle must end in time
   task automatic wait_idle();
      logic a;
      u_m.start();
      u_m.send(dev(1'b0), a);
      chk1(a, 1'b0);
      u_m.stop();
      for (int i = 0; i < 2000 && busy; i++)
         @(posedge ref_clk);
      #1;
      if (busy !== 1'b0) begin
         errors++;
         report_and_stop();
      end
   endtask
   task automatic set_addr(input logic [15:0] a);
      logic g;
      u_m.start();
      u_m.send(dev(1'b0), g);
      chk1(g, 1'b1);
      u_m.send(a[15:8], g);
      chk1(g, 1'b1);
      u_m.send(a[7:0], g);
      chk1(g, 1'b1);
   endtask
   // Every data byte is acknowledged; cyc says whether the stop starts a write cycle
   task automatic wr(input logic [15:0] a, input logic [7:0] d[$], input logic cyc);
      logic g;
      set_addr(a);
      foreach (d[i]) begin
         u_m.send(d[i], g);
         chk1(g, 1'b1);
      end
      u_m.stop();
      chk1(busy, cyc);
      if (cyc)
         wait_idle();
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e[$], input logic [7:0] m = 8'hFF);
      logic g;
      logic [7:0] b;
      set_addr(a);
      u_m.start();
      u_m.send(dev(1'b1), g);
      chk1(g, 1'b1);
      foreach (e[i]) begin
         u_m.recv(i < e.size() - 1, b);
         chk8(b & m, e[i] & m);
      end
      u_m.stop();
   endtask
   initial begin
      repeat (90000) @(posedge ref_clk);
      errors++;
      report_and_stop();
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      #1;
      srst = 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
      rd(16'hFFFF, '{8'h00});
      for (int s = 0; s < 8; s++) begin
         u_m.start();
         u_m.send({SEP_DEV_TYPE, s[2:0], 1'b0}, k);
         chk1(k, s[2:0] == SEL);
         u_m.stop();
      end
      u_m.start();
      u_m.send(dev(1'b0) ^ 8'h80, k);
      chk1(k, 1'b0);
      u_m.stop();
      wr(16'h0123, '{8'h3C}, 1'b0);
      wr(16'hFFFF, '{SEP_WPR_SET_WEL}, 1'b0);
      rd(16'hFFFF, '{8'h02});
      wr(16'h0123, '{8'h3C}, 1'b1);
      wr(16'h1FFF, '{8'h77}, 1'b1);
      wr(16'h0000, '{8'h88}, 1'b1);
      rd(16'h0123, '{8'h3C});
      rd(16'h1FFF, '{8'h77, 8'h88});
      // 34 bytes from byte 16: wrap inside the page, last two overwrite
      for (int i = 0; i < 34; i++)
         pg.push_back(8'(8'hA0 + i));
      ex = pg[0:31];
      for (int i = 0; i < 34; i++)
         ex[(16 + i) % 32] = pg[i];
      wr(16'h0450, pg, 1'b1);
      rd(16'h0440, ex);
      wr(16'hFFFF, '{SEP_WPR_SET_RWEL}, 1'b0);
      wr(16'hFFFF, '{8'h8E}, 1'b1);
      wr(16'h1FFF, '{8'h11}, 1'b0);
      wr(16'h17FF, '{8'h22}, 1'b1);
      rd(16'h1FFF, '{8'h77});
      wp = 1'b1;
      wr(16'hFFFF, '{SEP_WPR_SET_RWEL}, 1'b0);
      wr(16'hFFFF, '{8'h16}, 1'b0);
      rd(16'hFFFF, '{8'h88}, 8'h98);
      wp = 1'b0;
      wr(16'hFFFF, '{SEP_WPR_SET_RWEL}, 1'b0);
      wr(16'hFFFF, '{8'h16}, 1'b1);
      rd(16'hFFFF, '{8'h10}, 8'h98);
      wr(16'h1000, '{8'h33}, 1'b0);
      wr(16'h0FFF, '{8'h44}, 1'b1);
      rd(16'h0FFF, '{8'h44});
      wr(16'hFFFF, '{SEP_WPR_CLEAR}, 1'b0);
      wr(16'h0123, '{8'h55}, 1'b0);
      report_and_stop();
   end
endmodule
`default_nettype wire
